// ---- asfc_frame_control.sv ----
// frame control registers, pin routing, parity and quiet-line detection
//
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module asfc_frame_control (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // serial core side
   input wire logic txSerial,
   input wire logic txDriveDir,
   output logic rxSerial,
   input wire logic [8:0] txChar,
   output logic [8:0] txCharFramed,
   input wire logic [8:0] rxChar,
   input wire logic rxCharValid,
   output logic rxParityError,
   input wire logic bitTick,
   input wire logic rxStartBit,
   input wire logic rxStopBit,
   // flags from the data path
   input wire logic tx_buffer_empty_flag,
   input wire logic shift_done_flag,
   input wire logic rx_buffer_full_flag,
   // cpu wait input and mode outputs
   input wire logic cpuWait,
   output logic portClockRun,
   output logic nineBitMode,
   output logic addressMarkWake,
   output logic [3:0] enableLow,
   output logic irq,
   // pins
   output logic txPinOut,
   output logic txPinOe,
   input wire logic txPinIn,
   input wire logic rxPinIn
);
   logic [7:0] format_q, format_d;
   logic [7:0] enable_q, enable_d;
   logic quietFlag_q, quietFlag_d;
   logic [7:0] addr_q;
   logic wrPend_q;
   logic [31:0] hrdata_q, hrdata_d;
   logic rxSerial_q, txPinOut_q, txPinOe_q;
   logic [8:0] txCharFramed_q;
   logic rxParityError_q;
   logic [3:0] quietCnt_q, quietCnt_d;
   asfc_pkg::asfc_quiet_type quietSt_q, quietSt_d;

   // bus decode
   wire logic addrPhase = hsel && hready &&
      (htrans == asfc_pkg::HTRANS_NONSEQ || htrans == asfc_pkg::HTRANS_SEQ);
   wire logic wrFormat = wrPend_q && addr_q == asfc_pkg::FORMAT_OFFSET;
   wire logic wrEnable = wrPend_q && addr_q == asfc_pkg::ENABLE_OFFSET;
   wire logic wrStatus = wrPend_q && addr_q == asfc_pkg::STATUS_OFFSET;

   // mode fields
   wire logic loopSel = format_q[asfc_pkg::RETURN_SEL_BIT];
   wire logic inputSel = format_q[asfc_pkg::INPUT_SEL_BIT];
   wire logic nineBit = format_q[asfc_pkg::NINE_BIT];
   wire logic parityOn = format_q[asfc_pkg::PARITY_ON_BIT];
   wire logic parityOdd = format_q[asfc_pkg::PARITY_ODD_BIT];
   wire logic quietAfterStop = format_q[asfc_pkg::QUIET_ORIGIN_BIT];

   // port clocks stop only when freeze is set and the cpu waits
   wire logic clockRun = !(cpuWait && format_q[asfc_pkg::FREEZE_BIT]);

   // pin routing
   wire logic singleWire = loopSel && inputSel;
   wire logic rxSource = !loopSel ? rxPinIn :
      (inputSel ? txPinIn : txSerial);
   // internal return leaves the transmit pin undriven as well
   wire logic pinOe = !loopSel || (singleWire && txDriveDir);

   // parity: msb is eighth or ninth data bit
   wire logic dataOnes8 = ^txChar[6:0];
   wire logic dataOnes9 = ^txChar[7:0];
   wire logic txParity = (nineBit ? dataOnes9 : dataOnes8) ^ parityOdd;
   wire logic [8:0] txCharPar = nineBit ? {txParity, txChar[7:0]} :
      {1'b0, txParity, txChar[6:0]};
   wire logic [8:0] txCharPlain = nineBit ? txChar : {1'b0, txChar[7:0]};
   wire logic rxOnes = nineBit ? ^rxChar : ^rxChar[7:0];
   wire logic rxBadParity = parityOn && rxCharValid &&
      (rxOnes != parityOdd);

   // quiet-line threshold follows character length
   wire logic [3:0] quietLimit = nineBit ? asfc_pkg::QUIET_BITS_9 :
      asfc_pkg::QUIET_BITS_8;
   wire logic quietHit = clockRun && bitTick && rxSerial_q &&
      quietCnt_q == quietLimit - 4'h1;

   // interrupt request
   wire logic irqNow =
      (enable_q[asfc_pkg::TX_EMPTY_EN_BIT] && tx_buffer_empty_flag) ||
      (enable_q[asfc_pkg::SHIFT_DONE_EN_BIT] && shift_done_flag) ||
      (enable_q[asfc_pkg::RX_FULL_EN_BIT] && rx_buffer_full_flag) ||
      (enable_q[asfc_pkg::QUIET_EN_BIT] && quietFlag_q);

   // register next values
   assign format_d = wrFormat ? hwdata[7:0] : format_q;
   assign enable_d = wrEnable ? hwdata[7:0] : enable_q;
   // a new quiet detection wins over a software clear
   assign quietFlag_d = (quietSt_q == asfc_pkg::QUIET_COUNT && quietHit) ||
      (quietFlag_q && !(wrStatus && hwdata[asfc_pkg::ST_QUIET_BIT]));

   // read data built from next values, except the irq status bit, so back-to-back reads see writes
   wire logic [7:0] statusNow = {3'h0, irqNow, rx_buffer_full_flag,
      shift_done_flag, tx_buffer_empty_flag, quietFlag_d};
   always_comb begin
      hrdata_d = 32'h0;
      if (addrPhase && !hwrite) begin
         case (haddr)
            asfc_pkg::FORMAT_OFFSET: hrdata_d = {24'h0, format_d};
            asfc_pkg::ENABLE_OFFSET: hrdata_d = {24'h0, enable_d};
            asfc_pkg::STATUS_OFFSET: hrdata_d = {24'h0, statusNow};
            default: hrdata_d = 32'h0;
         endcase
      end
   end

   // quiet-line detector
   always_comb begin
      quietSt_d = quietSt_q;
      quietCnt_d = quietCnt_q;
      if (clockRun) begin
         case (quietSt_q)
            asfc_pkg::QUIET_WAIT: begin
               // origin after start bit or after stop bit
               if (quietAfterStop ? rxStopBit : rxStartBit) begin
                  quietSt_d = asfc_pkg::QUIET_COUNT;
                  quietCnt_d = 4'h0;
               end
            end
            asfc_pkg::QUIET_COUNT: begin
               if (quietAfterStop && rxStartBit) begin
                  quietSt_d = asfc_pkg::QUIET_WAIT;
               end else if (bitTick && !rxSerial_q) begin
                  quietCnt_d = 4'h0;
               end else if (quietHit) begin
                  quietSt_d = asfc_pkg::QUIET_DONE;
               end else if (bitTick) begin
                  quietCnt_d = quietCnt_q + 4'h1;
               end
            end
            asfc_pkg::QUIET_DONE: begin
               // one detection per quiet stretch; a start bit may rearm
               if (!quietAfterStop && rxStartBit) begin
                  quietSt_d = asfc_pkg::QUIET_COUNT;
                  quietCnt_d = 4'h0;
               end else if (rxStartBit) begin
                  quietSt_d = asfc_pkg::QUIET_WAIT;
               end
            end
            default: quietSt_d = asfc_pkg::QUIET_WAIT;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         format_q <= asfc_pkg::FORMAT_RESET;
         enable_q <= asfc_pkg::ENABLE_RESET;
         quietFlag_q <= 1'b0;
         addr_q <= 8'h00;
         wrPend_q <= 1'b0;
         hrdata_q <= 32'h0;
      end else begin
         format_q <= format_d;
         enable_q <= enable_d;
         quietFlag_q <= quietFlag_d;
         addr_q <= haddr;
         wrPend_q <= addrPhase && hwrite && hsize == 3'h2;
         hrdata_q <= hrdata_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rxSerial_q <= 1'b1;
         txPinOut_q <= 1'b1;
         txPinOe_q <= 1'b0;
         txCharFramed_q <= 9'h000;
         rxParityError_q <= 1'b0;
         quietCnt_q <= 4'h0;
         quietSt_q <= asfc_pkg::QUIET_WAIT;
      end else begin
         rxSerial_q <= rxSource;
         txPinOut_q <= txSerial;
         txPinOe_q <= pinOe;
         txCharFramed_q <= parityOn ? txCharPar : txCharPlain;
         rxParityError_q <= rxBadParity;
         quietCnt_q <= quietCnt_d;
         quietSt_q <= quietSt_d;
      end
   end

   // outputs
   assign hreadyout = 1'b1;
   assign hresp = asfc_pkg::HRESP_OKAY;
   assign hrdata = hrdata_q;
   assign rxSerial = rxSerial_q;
   assign txPinOut = txPinOut_q;
   assign txPinOe = txPinOe_q;
   assign txCharFramed = txCharFramed_q;
   assign rxParityError = rxParityError_q;
   assign portClockRun = clockRun;
   assign nineBitMode = nineBit;
   assign addressMarkWake = format_q[asfc_pkg::WAKE_BIT];
   assign enableLow = enable_q[3:0];
   assign irq = irqNow;

   // checks
   AST_LOOP_RETURN: assert property (@(posedge ref_clk) disable iff (reset)
      loopSel && !inputSel |=> rxSerial_q == $past(txSerial))
      else $error("loop return does not follow transmitter");
   AST_NORMAL_PINS: assert property (@(posedge ref_clk) disable iff (reset)
      !reset && !loopSel |=> rxSerial_q == $past(rxPinIn) && txPinOe_q)
      else $error("normal mode pin routing wrong");
   AST_CLOCK_RUN: assert property (@(posedge ref_clk) disable iff (reset)
      !format_q[asfc_pkg::FREEZE_BIT] |-> portClockRun)
      else $error("port clock stopped with freeze clear");
   AST_CLOCK_FREEZE: assert property (@(posedge ref_clk) disable iff (reset)
      format_q[asfc_pkg::FREEZE_BIT] && cpuWait |-> !portClockRun &&
      $stable(quietCnt_q) ##1 quietCnt_q == $past(quietCnt_q))
      else $error("port clock running during frozen wait");
   AST_SELECT_IGNORED: assert property (@(posedge ref_clk) disable iff (reset)
      !loopSel |=> rxSerial_q == $past(rxPinIn))
      else $error("input select acts without loop mode");
   AST_INTERNAL_PIN_OFF: assert property (@(posedge ref_clk)
      disable iff (reset) loopSel && !inputSel |=> !txPinOe_q)
      else $error("transmit pin driven in internal return");
   AST_SINGLE_WIRE: assert property (@(posedge ref_clk) disable iff (reset)
      singleWire |=> rxSerial_q == $past(txPinIn) &&
      txPinOe_q == $past(txDriveDir))
      else $error("single wire routing wrong");
   AST_QUIET_LIMIT: assert property (@(posedge ref_clk) disable iff (reset)
      quietSt_q == asfc_pkg::QUIET_COUNT |-> quietCnt_q < quietLimit)
      else $error("quiet count passed its limit");
   AST_QUIET_SET: assert property (@(posedge ref_clk) disable iff (reset)
      quietSt_q == asfc_pkg::QUIET_COUNT && quietHit |=>
      quietFlag_q && quietSt_q == asfc_pkg::QUIET_DONE)
      else $error("quiet flag not raised at limit");
   AST_PARITY_TX: assert property (@(posedge ref_clk) disable iff (reset)
      parityOn && !nineBit |=> ^$past(txCharFramed_q[7:0]) ==
      $past(parityOdd) || ^txCharFramed_q[7:0] == $past(parityOdd))
      else $error("generated parity wrong");
   AST_PARITY_RX: assert property (@(posedge ref_clk) disable iff (reset)
      !parityOn || !rxCharValid |=> !rxParityError_q)
      else $error("parity error without checked character");
   AST_IRQ: assert property (@(posedge ref_clk) disable iff (reset)
      irq == ((enable_q[7] && tx_buffer_empty_flag) ||
      (enable_q[6] && shift_done_flag) || (enable_q[5] &&
      rx_buffer_full_flag) || (enable_q[4] && quietFlag_q)))
      else $error("interrupt request mismatch");
   AST_ENABLE_WRITE: assert property (@(posedge ref_clk) disable iff (reset)
      wrEnable |=> enable_q == $past(hwdata[7:0]))
      else $error("enable register write lost");
   AST_LENGTH: assert property (@(posedge ref_clk) disable iff (reset)
      nineBitMode == format_q[asfc_pkg::NINE_BIT] &&
      quietLimit == (nineBit ? 4'hb : 4'ha))
      else $error("character length mismatch");
   AST_WAKE: assert property (@(posedge ref_clk) disable iff (reset)
      wrFormat |=> addressMarkWake == $past(hwdata[3]))
      else $error("wake method not taken");

   // register and bus checks
   AST_FORMAT_WRITE: assert property (@(posedge ref_clk) disable iff (reset)
      wrFormat |=> format_q == $past(hwdata[7:0]))
      else $error("format register write lost");
   AST_FORMAT_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
      !wrFormat |=> $stable(format_q))
      else $error("format register changed without write");
   AST_ENABLE_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
      !wrEnable |=> $stable(enable_q))
      else $error("enable register changed without write");
   AST_BUS_OKAY: assert property (@(posedge ref_clk) disable iff (reset)
      hreadyout && hresp == asfc_pkg::HRESP_OKAY)
      else $error("bus answer not ready and okay");
   AST_READ_IDLE: assert property (@(posedge ref_clk) disable iff (reset)
      !(addrPhase && !hwrite) |=> hrdata_q == 32'h0)
      else $error("read data outside a read");

   // pin checks
   AST_TX_PIN_FOLLOW: assert property (@(posedge ref_clk)
      disable iff (reset) !reset |=> txPinOut_q == $past(txSerial))
      else $error("transmit pin does not follow transmitter");
   AST_RX_PIN_UNUSED: assert property (@(posedge ref_clk)
      disable iff (reset)
      loopSel |-> rxSource == (inputSel ? txPinIn : txSerial))
      else $error("receive pin used in loop mode");
   AST_SINGLE_RELEASE: assert property (@(posedge ref_clk)
      disable iff (reset) singleWire && !txDriveDir |=> !txPinOe_q)
      else $error("single wire pin driven while receiving");

   // parity checks
   AST_PLAIN_TX: assert property (@(posedge ref_clk) disable iff (reset)
      !parityOn |=> txCharFramed_q == $past(txCharPlain))
      else $error("character altered with parity off");
   AST_PAR_TX9: assert property (@(posedge ref_clk) disable iff (reset)
      parityOn && nineBit |=> ^txCharFramed_q == $past(parityOdd))
      else $error("nine bit parity wrong");
   AST_PAR_TX8: assert property (@(posedge ref_clk) disable iff (reset)
      parityOn && !nineBit |=> ^txCharFramed_q[7:0] == $past(parityOdd) &&
      !txCharFramed_q[8])
      else $error("eight bit parity wrong");
   AST_PAR_RX_ERR: assert property (@(posedge ref_clk) disable iff (reset)
      parityOn && rxCharValid && rxOnes != parityOdd |=>
      rxParityError_q)
      else $error("parity error missed");
   AST_PAR_RX_OK: assert property (@(posedge ref_clk) disable iff (reset)
      parityOn && rxCharValid && rxOnes == parityOdd |=>
      !rxParityError_q)
      else $error("parity error on good character");

   // quiet-line checks
   AST_FREEZE_STATE: assert property (@(posedge ref_clk) disable iff (reset)
      !portClockRun |=> quietSt_q == $past(quietSt_q))
      else $error("quiet detector moved while frozen");
   AST_QUIET_ARM: assert property (@(posedge ref_clk) disable iff (reset)
      quietSt_q == asfc_pkg::QUIET_WAIT && portClockRun &&
      (quietAfterStop ? rxStopBit : rxStartBit) |=>
      quietSt_q == asfc_pkg::QUIET_COUNT && quietCnt_q == 4'h0)
      else $error("quiet count not armed at origin");
   AST_QUIET_REARM: assert property (@(posedge ref_clk) disable iff (reset)
      quietSt_q == asfc_pkg::QUIET_DONE && portClockRun &&
      !quietAfterStop && rxStartBit |=>
      quietSt_q == asfc_pkg::QUIET_COUNT && quietCnt_q == 4'h0)
      else $error("quiet count not rearmed by start bit");
   AST_QUIET_LOW: assert property (@(posedge ref_clk) disable iff (reset)
      quietSt_q == asfc_pkg::QUIET_COUNT && portClockRun && bitTick &&
      !rxSerial_q && !(quietAfterStop && rxStartBit) |=>
      quietCnt_q == 4'h0)
      else $error("low bit did not restart quiet count");
   AST_QUIET_DISARM: assert property (@(posedge ref_clk) disable iff (reset)
      quietSt_q == asfc_pkg::QUIET_COUNT && portClockRun &&
      quietAfterStop && rxStartBit |=>
      quietSt_q == asfc_pkg::QUIET_WAIT)
      else $error("start bit did not disarm stop-origin count");
   AST_QUIET_CLEAR: assert property (@(posedge ref_clk) disable iff (reset)
      quietFlag_q && wrStatus && hwdata[asfc_pkg::ST_QUIET_BIT] &&
      !(quietSt_q == asfc_pkg::QUIET_COUNT && quietHit) |=> !quietFlag_q)
      else $error("quiet flag not cleared");
   AST_QUIET_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
      quietFlag_q && !wrStatus |=> quietFlag_q)
      else $error("quiet flag dropped without clear");

   // interrupt checks
   AST_IRQ_TX_EMPTY: assert property (@(posedge ref_clk) disable iff (reset)
      enable_q[asfc_pkg::TX_EMPTY_EN_BIT] && tx_buffer_empty_flag |-> irq)
      else $error("transmit empty request missing");
   AST_IRQ_SHIFT: assert property (@(posedge ref_clk) disable iff (reset)
      enable_q[asfc_pkg::SHIFT_DONE_EN_BIT] && shift_done_flag |-> irq)
      else $error("shift done request missing");
   AST_IRQ_RX_FULL: assert property (@(posedge ref_clk) disable iff (reset)
      enable_q[asfc_pkg::RX_FULL_EN_BIT] && rx_buffer_full_flag |-> irq)
      else $error("receive full request missing");
   AST_IRQ_QUIET: assert property (@(posedge ref_clk) disable iff (reset)
      enable_q[asfc_pkg::QUIET_EN_BIT] && quietFlag_q |-> irq)
      else $error("quiet line request missing");
   AST_IRQ_NONE: assert property (@(posedge ref_clk) disable iff (reset)
      enable_q[7:4] == 4'h0 |-> !irq)
      else $error("request raised with all enables clear");
endmodule
`default_nettype wire

// ---- asfc_pkg.sv ----
// shared constants for the serial frame control block
package asfc_pkg;
   // register byte offsets
   localparam logic [7:0] FORMAT_OFFSET = 8'h00;
   localparam logic [7:0] ENABLE_OFFSET = 8'h04;
   localparam logic [7:0] STATUS_OFFSET = 8'h08;
   // reset values
   localparam logic [7:0] FORMAT_RESET = 8'h00;
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   // format register fields
   localparam int RETURN_SEL_BIT = 7;
   localparam int FREEZE_BIT = 6;
   localparam int INPUT_SEL_BIT = 5;
   localparam int NINE_BIT = 4;
   localparam int WAKE_BIT = 3;
   localparam int QUIET_ORIGIN_BIT = 2;
   localparam int PARITY_ON_BIT = 1;
   localparam int PARITY_ODD_BIT = 0;
   // enable register fields
   localparam int TX_EMPTY_EN_BIT = 7;
   localparam int SHIFT_DONE_EN_BIT = 6;
   localparam int RX_FULL_EN_BIT = 5;
   localparam int QUIET_EN_BIT = 4;
   // status register fields
   localparam int ST_QUIET_BIT = 0;
   localparam int ST_TX_EMPTY_BIT = 1;
   localparam int ST_SHIFT_DONE_BIT = 2;
   localparam int ST_RX_FULL_BIT = 3;
   localparam int ST_IRQ_BIT = 4;
   // quiet-line thresholds in bit times
   localparam logic [3:0] QUIET_BITS_8 = 4'ha;
   localparam logic [3:0] QUIET_BITS_9 = 4'hb;
   // ahb encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;
   localparam logic HRESP_OKAY = 1'b0;
   // quiet detector states
   typedef enum logic [1:0] {QUIET_WAIT, QUIET_COUNT, QUIET_DONE}
      asfc_quiet_type;
endpackage

// ---- asfc_remote_node.sv ----
// remote serial node that drives the port's receive pin
`timescale 1ns/1ps
`default_nettype none
module asfc_remote_node #(parameter int BIT_CYC = 4) (
   // clock
   input wire logic clk,
   // line toward the port, idles high
   output logic line
);
   initial line = 1'h1;
   task automatic hold(input logic lvl);
      line <= lvl;
   endtask
   // a whole frame; the line is left at the stop level, its idle level
   task automatic send(input logic [8:0] d, input logic nine);
      logic [10:0] f;
      f = nine ? {1'h1, d, 1'h0} : {2'h3, d[7:0], 1'h0};
      for (int i = 0; i < (nine ? 11 : 10); i++) begin
         @(posedge clk);
         line <= f[i];
         repeat (BIT_CYC - 1) @(posedge clk);
      end
   endtask
endmodule
`default_nettype wire

// ---- tb_async_serial_frame_control.sv ----
// self-checking bench for the serial frame control block
`timescale 1ns/1ps
`default_nettype none
module tb_async_serial_frame_control;
   logic ref_clk = 1'h0, reset = 1'h1, hsel = 1'h0, hwrite = 1'h0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0, hrdata;
   logic hreadyout, hresp, rxSerial, rxParityError, portClockRun, irq;
   logic nineBitMode, addressMarkWake, txPinOut, txPinOe, rxPinIn;
   logic [8:0] txChar = 9'h0, rxChar = 9'h0, txCharFramed;
   logic [3:0] enableLow;
   logic txSerial = 1'h1, txDriveDir = 1'h0, rxCharValid = 1'h0;
   logic bitTick = 1'h0, rxStartBit = 1'h0, rxStopBit = 1'h0;
   logic txEmpty = 1'h0, shiftDone = 1'h0, rxFull = 1'h0;
   logic cpuWait = 1'h0, farPin = 1'h1;
   int bad_count = 0, num_checks = 0;
   // shared pin: whoever enables drives it
   wire logic txWire = txPinOe ? txPinOut : farPin;
   asfc_frame_control asfc_frame_control_inst (.ref_clk(ref_clk),
      .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .txSerial(txSerial), .txDriveDir(txDriveDir), .rxSerial(rxSerial),
      .txChar(txChar), .txCharFramed(txCharFramed), .rxChar(rxChar),
      .rxCharValid(rxCharValid), .rxParityError(rxParityError),
      .bitTick(bitTick), .rxStartBit(rxStartBit), .rxStopBit(rxStopBit),
      .tx_buffer_empty_flag(txEmpty), .shift_done_flag(shiftDone),
      .rx_buffer_full_flag(rxFull), .cpuWait(cpuWait),
      .portClockRun(portClockRun), .nineBitMode(nineBitMode),
      .addressMarkWake(addressMarkWake), .enableLow(enableLow), .irq(irq),
      .txPinOut(txPinOut), .txPinOe(txPinOe), .txPinIn(txWire),
      .rxPinIn(rxPinIn));
   asfc_remote_node #(.BIT_CYC(4)) asfc_remote_node_inst (.clk(ref_clk),
      .line(rxPinIn));
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, got);
      num_checks++;
      if (got !== ex) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   // master holds each phase until hready is seen high
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge ref_clk);
      hsel <= 1'h1;
      haddr <= a;
      hwrite <= w;
      htrans <= asfc_pkg::HTRANS_NONSEQ;
      do @(posedge ref_clk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge ref_clk); while (hreadyout !== 1'h1);
      rd = hrdata;
      hsel <= 1'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'h1, a, d, x);
   endtask
   task automatic rdchk(input string nm, input logic [7:0] a,
      input logic [31:0] ex);
      logic [31:0] x;
      bus(1'h0, a, 32'h0, x);
      chk(nm, ex, x);
   endtask
   task automatic t_regs();
      rdchk("format", 8'h00, 32'(asfc_pkg::FORMAT_RESET));
      rdchk("enable", 8'h04, 32'(asfc_pkg::ENABLE_RESET));
      wr(8'h04, 32'ha5);
      rdchk("enable", 8'h04, 32'ha5);
      chk("enableLow", 32'h5, 32'(enableLow));
      chk("hresp", 32'h0, 32'(hresp));
      wr(8'h0c, 32'hffffffff);
      rdchk("unmapped", 8'h0c, 32'h0);
      wr(8'h04, 32'h0);
   endtask
   task automatic t_mode();
      cpuWait <= 1'h1;
      @(posedge ref_clk);
      #1 chk("run", 32'h1, 32'(portClockRun));
      wr(8'h00, 32'h48);
      #1 chk("run", 32'h0, 32'(portClockRun));
      chk("wake", 32'h1, 32'(addressMarkWake));
      @(posedge ref_clk);
      cpuWait <= 1'h0;
      @(posedge ref_clk);
      #1 chk("run", 32'h1, 32'(portClockRun));
   endtask
   task automatic t_frame(input logic nine, input logic [8:0] d);
      logic [10:0] got, ex;
      got = 11'h7ff;
      ex = nine ? {1'h1, d, 1'h0} : {2'h3, d[7:0], 1'h0};
      wr(8'h00, {27'h0, nine, 4'h0});
      fork
         asfc_remote_node_inst.send(d, nine);
         begin
            @(negedge rxSerial);
            repeat (2) @(posedge ref_clk);
            for (int i = 0; i < (nine ? 11 : 10); i++) begin
               got[i] = rxSerial;
               repeat (4) @(posedge ref_clk);
            end
         end
      join
      chk("frame", 32'(ex), 32'(got));
   endtask
   task automatic rcase(input logic [7:0] f, input logic [3:0] v,
      input logic [1:0] e);
      wr(8'h00, {24'h0, f});
      txSerial <= v[3];
      txDriveDir <= v[2];
      farPin <= v[1];
      asfc_remote_node_inst.hold(v[0]);
      repeat (3) @(posedge ref_clk);
      #1 chk("rxSerial", 32'(e[1]), 32'(rxSerial));
      chk("txPinOe", 32'(e[0]), 32'(txPinOe));
      chk("txPinOut", 32'(v[3]), 32'(txPinOut));
   endtask
   task automatic rxc(input logic [8:0] c, input logic e);
      @(posedge ref_clk);
      rxChar <= c;
      rxCharValid <= 1'h1;
      @(posedge ref_clk);
      rxCharValid <= 1'h0;
      #1 chk("rxParityError", 32'(e), 32'(rxParityError));
   endtask
   task automatic t_parity();
      logic [8:0] d, e;
      logic p;
      for (int i = 0; i < 8; i++) begin
         d = 9'h0b5 + 9'(i * 35);
         p = (i[2] ? ^d[7:0] : ^d[6:0]) ^ i[0];
         e = i[2] ? d : {1'h0, d[7:0]};
         if (i[1]) e = i[2] ? {p, d[7:0]} : {1'h0, p, d[6:0]};
         wr(8'h00, {27'h0, i[2], 2'h0, i[1:0]});
         txChar <= d;
         repeat (2) @(posedge ref_clk);
         #1 chk("txCharFramed", 32'(e), 32'(txCharFramed));
         chk("nineBitMode", 32'(i[2]), 32'(nineBitMode));
         rxc(e, 1'h0);
         rxc(e ^ 9'h1, i[1]);
      end
   endtask
   task automatic t_irq();
      logic [2:0] m;
      for (int k = 0; k < 3; k++) begin
         m = 3'h4 >> k;
         wr(8'h04, 32'h80 >> k);
         {txEmpty, shiftDone, rxFull} <= ~m;
         @(posedge ref_clk);
         #1 chk("irq off", 32'h0, 32'(irq));
         @(posedge ref_clk);
         {txEmpty, shiftDone, rxFull} <= m;
         @(posedge ref_clk);
         #1 chk("irq on", 32'h1, 32'(irq));
         @(posedge ref_clk);
         {txEmpty, shiftDone, rxFull} <= 3'h0;
      end
   endtask
   // origin pulse, then ticks with the line high
   task automatic t_quiet(input logic nine, org, st, ex);
      wr(8'h04, 32'h10);
      wr(8'h00, {27'h0, nine, 1'h0, org, 2'h0});
      rxStopBit <= st;
      rxStartBit <= !st;
      @(posedge ref_clk);
      rxStopBit <= 1'h0;
      rxStartBit <= 1'h0;
      for (int i = 0; i < (nine ? 11 : 10); i++) begin
         if (i == (nine ? 10 : 9)) rdchk("quiet early", 8'h08, 32'h0);
         @(posedge ref_clk);
         bitTick <= 1'h1;
         @(posedge ref_clk);
         bitTick <= 1'h0;
      end
      repeat (3) @(posedge ref_clk);
      #1 chk("quiet irq", 32'(ex), 32'(irq));
      rdchk("quiet", 8'h08, ex ? 32'h11 : 32'h0);
      wr(8'h08, 32'h1);
      rdchk("quiet clear", 8'h08, 32'h0);
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      reset <= 1'h0;
      t_regs();
      t_mode();
      t_frame(1'h0, 9'h0a5);
      t_frame(1'h1, 9'h15a);
      rcase(8'h00, 4'ha, 2'h1);
      rcase(8'h00, 4'h5, 2'h3);
      rcase(8'h20, 4'ha, 2'h1);
      rcase(8'h80, 4'h3, 2'h0);
      rcase(8'h80, 4'h8, 2'h2);
      rcase(8'ha0, 4'h9, 2'h0);
      rcase(8'ha0, 4'hd, 2'h3);
      t_parity();
      t_irq();
      t_quiet(1'h0, 1'h0, 1'h0, 1'h1);
      t_quiet(1'h1, 1'h0, 1'h0, 1'h1);
      t_quiet(1'h0, 1'h1, 1'h0, 1'h0);
      t_quiet(1'h1, 1'h1, 1'h1, 1'h1);
      give_verdict();
   end
   // whole run needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      give_verdict();
   end
endmodule
`default_nettype wire
